/* dv/dspm_board_model.sv */
// board model: resolves the two shared pins between device and board drivers
// assumes the bench sets what the board drives on each pin and when it lets go
`timescale 1ns/1ps
`default_nettype none

module dspm_board_model (
	input  wire logic clk_sys,
	input  wire logic pf6_pin_o,
	input  wire logic pf6_pin_oe,
	input  wire logic pf7_pin_o,
	input  wire logic pf7_pin_oe,
	input  wire logic board6_en,
	input  wire logic board6_lvl,
	input  wire logic board7_en,
	input  wire logic board7_lvl,
	output logic      pf6_pin_i,
	output logic      pf7_pin_i
);
	logic last6_q = 1'b0;
	logic last7_q = 1'b0;

	// device drive wins; a pin nobody drives flips each cycle so a stale level never passes
	assign pf6_pin_i = pf6_pin_oe ? pf6_pin_o : (board6_en ? board6_lvl : ~last6_q);
	assign pf7_pin_i = pf7_pin_oe ? pf7_pin_o : (board7_en ? board7_lvl : ~last7_q);

	// remember the last wire levels
	always_ff @(posedge clk_sys) begin
		last6_q <= pf6_pin_i;
		last7_q <= pf7_pin_i;
	end
endmodule : dspm_board_model
`default_nettype wire

/* dv/tb_dram_strobe_pin_mux.sv */
// bench: axi4-lite register access, shared pin selection, trigger, analog and dram strobes
// assumes the board model resolves the shared pins and the design answers the bus itself
`timescale 1ns/1ps
`default_nettype none
`include "dspm_cfg.svh"

module tb_dram_strobe_pin_mux;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, p6_i, p6_o, p6_oe, p7_i, p7_o, p7_oe, p6_in, p7_in, trig;
	logic [1:0]  bresp, rresp, rs, e, own;
	logic        ser = 1'b0, t2 = 1'b0, t0 = 1'b0, dat6 = 1'b0, dir6 = 1'b0, dat7 = 1'b0, dir7 = 1'b0;
	logic        b7 = 1'b0, ras4 = 1'b0, ras5 = 1'b0, cas = 1'b0, we = 1'b0, a0 = 1'b0;
	logic [3:0]  an_i = 4'h0, an_en, an_dig;
	logic [7:0]  strb, exp8;
	logic [3:0]  wstrb = 4'hF;
	logic [9:0]  ctrl;
	int          bad_count = 0, num_checks = 0, cycles = 0, seed = 32'hf28b, i, m, n;

	dspm_top #(.AN_COUNT(4)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .serial2_tx_out(ser), .timer_out_two(t2), .timer_out_zero(t0),
		.port_f_bit_six_dat(dat6), .port_f_bit_six_dir(dir6), .port_f_bit_seven_dat(dat7),
		.port_f_bit_seven_dir(dir7), .pf6_pin_i(p6_i), .pf6_pin_o(p6_o), .pf6_pin_oe(p6_oe),
		.pf7_pin_i(p7_i), .pf7_pin_o(p7_o), .pf7_pin_oe(p7_oe), .analog_pin_i(an_i),
		.port_f_bit_six_in(p6_in), .port_f_bit_seven_in(p7_in), .converter_ext_trigger(trig),
		.analog_inputs_en(an_en), .analog_digital_in(an_dig), .dram_ras4_req(ras4), .dram_ras5_req(ras5),
		.dram_cas_req(cas), .dram_we_req(we), .dram_addr0(a0), .row_strobe_area4_n(strb[7]),
		.row_strobe_area5_n(strb[6]), .area4_low_lane_select_n(strb[5]), .area4_high_lane_select_n(strb[4]),
		.area4_write_enable_n(strb[3]), .area5_low_lane_select_n(strb[2]),
		.area5_high_lane_select_n(strb[1]), .area5_write_enable_n(strb[0]));

	dspm_board_model u_board (.clk_sys(clk_sys), .pf6_pin_o(p6_o), .pf6_pin_oe(p6_oe), .pf7_pin_o(p7_o),
		.pf7_pin_oe(p7_oe), .board6_en(1'b0), .board6_lvl(1'b0), .board7_en(1'b1), .board7_lvl(b7),
		.pf6_pin_i(p6_i), .pf7_pin_i(p7_i));

	// clock and hang guard; the whole run needs under a thousand cycles
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles > 8000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// write: address and data offered together, each dropped when taken, bready held until bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		r = 2'h3;
		forever begin
			@(posedge clk_sys);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd

	// reference strobes of one area: {low lane, high lane, write enable}, all active low
	function automatic logic [2:0] area(input logic [1:0] md, input logic r, c, w, a);
		case (md)
			2'h1: return {~(r & c & ~a), ~(r & c & a), ~(r & w)};
			2'h2: return {~(r & c), ~(r & w & ~a), ~(r & w & a)};
			default: return {~(r & c), ~(r & c), ~(r & w)};
		endcase
	endfunction : area

	// reference owner of each shared pin: {drive enable, drive value}
	function automatic logic [1:0] pin6(input logic [9:0] c);
		if (c[0]) return {1'b1, ser};
		if (c[1]) return {1'b1, t2};
		return {dir6, dat6};
	endfunction : pin6

	function automatic logic [1:0] pin7(input logic [9:0] c);
		if (c[2]) return {1'b1, t0};
		if (c[3]) return {1'b0, dat7};
		return {dir7, dat7};
	endfunction : pin7

	// main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		#1 check(32'(strb), 32'h0000_00FF);
		rd(`DSPM_CTRL_OFF, rv, rs);
		check(rv, 32'h0);
		wr(`DSPM_CTRL_OFF, 32'hFFFFFFFF, rs);
		check(32'(rs), 32'(`DSPM_RESP_OKAY));
		rd(`DSPM_CTRL_OFF, rv, rs);
		check(rv, 32'h3FF);
		// byte lane zero alone clears the low control bits and keeps the mode bits
		wstrb <= 4'h1;
		wr(`DSPM_CTRL_OFF, 32'h0, rs);
		wstrb <= 4'hF;
		check(32'(rs), 32'(`DSPM_RESP_OKAY));
		rd(`DSPM_CTRL_OFF, rv, rs);
		check(rv, 32'h300);
		wr(`DSPM_STAT_OFF, 32'hFFFFFFFF, rs);
		check(32'(rs), 32'(`DSPM_RESP_OKAY));
		wr(8'h08, 32'h1, rs);
		check(32'(rs), 32'(`DSPM_RESP_SLVERR));
		rd(8'h08, rv, rs);
		check(rv, 32'h0);
		check(32'(rs), 32'(`DSPM_RESP_SLVERR));
		// random pin ownership, peripherals and port fighting for the same pins
		for (i = 0; i < 48; i++) begin
			ctrl = 10'($random(seed));
			wr(`DSPM_CTRL_OFF, {22'h0, ctrl}, rs);
			{ser, t2, t0, dat6, dir6, dat7, dir7} <= 7'($random(seed));
			// four edges so a driven level also comes back through the synchroniser
			repeat (4) @(posedge clk_sys);
			#1 e = pin6(ctrl);
			check(32'({p6_oe, p6_o & p6_oe}), 32'({e[1], e[0] & e[1]}));
			check(32'(p6_in & e[1]), 32'(e[0] & e[1]));
			e = pin7(ctrl);
			check(32'({p7_oe, p7_o & p7_oe}), 32'({e[1], e[0] & e[1]}));
			check(32'(p7_in & e[1]), 32'(e[0] & e[1]));
			// owner codes in the status word
			own = ctrl[2] ? 2'h1 : (ctrl[3] ? 2'h3 : 2'h0);
			e = ctrl[0] ? 2'h1 : (ctrl[1] ? 2'h2 : 2'h0);
			rd(`DSPM_STAT_OFF, rv, rs);
			check(32'(rv[3:0]), 32'({own, e}));
		end
		// trigger edge counted only while external triggering is selected
		dir7 <= 1'b0;
		wr(`DSPM_CTRL_OFF, 32'h8, rs);
		for (i = 0; i < 2; i++) begin
			b7 <= 1'b0;
			repeat (5) @(posedge clk_sys);
			b7 <= 1'b1;
			n = 0;
			repeat (8) begin
				@(posedge clk_sys);
				if (trig === 1'b1) n++;
			end
			check(n, (i == 0) ? 1 : 0);
			check(32'(p7_in), 32'h0000_0001);
			wr(`DSPM_CTRL_OFF, 32'h0, rs);
		end
		// analog select masks the digital level
		for (i = 0; i < 6; i++) begin
			ctrl = 10'($random(seed));
			wr(`DSPM_CTRL_OFF, {22'h0, ctrl}, rs);
			an_i <= 4'($random(seed));
			repeat (5) @(posedge clk_sys);
			#1 check(32'({an_en, an_dig}), 32'({ctrl[7:4], an_i & ~ctrl[7:4]}));
		end
		// every bus mode with random strobe requests
		for (m = 0; m < 4; m++) begin
			wr(`DSPM_CTRL_OFF, m << `DSPM_MODE_LSB, rs);
			for (i = 0; i < 24; i++) begin
				@(posedge clk_sys);
				{ras4, ras5, cas, we, a0} <= 5'($random(seed));
				@(posedge clk_sys);
				#1 exp8 = {~ras4, ~ras5, area(m[1:0], ras4, cas, we, a0), area(m[1:0], ras5, cas, we, a0)};
				check(32'(strb), 32'(exp8));
			end
		end
		conclude();
	end
endmodule : tb_dram_strobe_pin_mux
`default_nettype wire

/* include/dspm_cfg.svh */
// dram strobe pin mux: register offsets, field positions and reset values
// assumes a 32-bit AXI4-Lite register bus with byte addresses
`ifndef DSPM_CFG_SVH
`define DSPM_CFG_SVH

// register bus address width and register offsets (byte addresses)
`define DSPM_ADDR_W        8
`define DSPM_CTRL_OFF      8'h00
`define DSPM_STAT_OFF      8'h04

// control register layout
`define DSPM_CTRL_W        10
`define DSPM_CTRL_RST      10'h000
`define DSPM_SER2_OE_BIT   0
`define DSPM_TMR2_EN_BIT   1
`define DSPM_TMR0_EN_BIT   2
`define DSPM_EXT_TRIG_BIT  3
`define DSPM_AIC_LSB       4
`define DSPM_AIC_W         4
`define DSPM_MODE_LSB      8

// bus answers
`define DSPM_RESP_OKAY     2'h0
`define DSPM_RESP_SLVERR   2'h2

`endif

/* include/dspm_pkg.sv */
// dram strobe pin mux: shared types
// assumes dspm_cfg.svh supplies the numeric constants
package dspm_pkg;

	// data bus width and strobe arrangement of both dram areas
	typedef enum logic [1:0] {
		DSPM_BUS8       = 2'h0,
		DSPM_BUS16_2CAS = 2'h1,
		DSPM_BUS16_1CAS = 2'h2
	} dspm_bus_mode_t;

	// which function owns a shared pin
	typedef enum logic [1:0] {
		DSPM_SRC_PORT   = 2'h0,
		DSPM_SRC_PERA   = 2'h1,
		DSPM_SRC_PERB   = 2'h2,
		DSPM_SRC_INPUT  = 2'h3
	} dspm_pin_src_t;

endpackage : dspm_pkg

/* src/dspm_sync.sv */
// dram strobe pin mux: two-flop synchroniser for pin levels
// assumes inputs are levels from outside the clk_sys domain
`timescale 1ns/1ps
`default_nettype none

module dspm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage, never any logic
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : dspm_sync

`default_nettype wire

/* src/dspm_top.sv */
// dram strobe pin mux: shared pin selection and dram strobe mapping
// assumes peripherals, port logic and bus controller run on clk_sys
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dspm_cfg.svh"

module dspm_top import dspm_pkg::*; #(
	parameter int AN_COUNT = 4
) (
	input  wire logic                    clk_sys,
	input  wire logic                    resetn,
	input  wire logic [`DSPM_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [`DSPM_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    serial2_tx_out,
	input  wire logic                    timer_out_two,
	input  wire logic                    timer_out_zero,
	input  wire logic                    port_f_bit_six_dat,
	input  wire logic                    port_f_bit_six_dir,
	input  wire logic                    port_f_bit_seven_dat,
	input  wire logic                    port_f_bit_seven_dir,
	input  wire logic                    pf6_pin_i,
	output logic                         pf6_pin_o,
	output logic                         pf6_pin_oe,
	input  wire logic                    pf7_pin_i,
	output logic                         pf7_pin_o,
	output logic                         pf7_pin_oe,
	input  wire logic [AN_COUNT-1:0]     analog_pin_i,
	output logic                         port_f_bit_six_in,
	output logic                         port_f_bit_seven_in,
	output logic                         converter_ext_trigger,
	output logic [AN_COUNT-1:0]          analog_inputs_en,
	output logic [AN_COUNT-1:0]          analog_digital_in,
	input  wire logic                    dram_ras4_req,
	input  wire logic                    dram_ras5_req,
	input  wire logic                    dram_cas_req,
	input  wire logic                    dram_we_req,
	input  wire logic                    dram_addr0,
	output logic                         row_strobe_area4_n,
	output logic                         row_strobe_area5_n,
	output logic                         area4_low_lane_select_n,
	output logic                         area4_high_lane_select_n,
	output logic                         area5_low_lane_select_n,
	output logic                         area5_high_lane_select_n,
	output logic                         area4_write_enable_n,
	output logic                         area5_write_enable_n
);

	// the select register field is four bits wide
	if (AN_COUNT < 1 || AN_COUNT > `DSPM_AIC_W) begin : g_bad_an_count
		$error("AN_COUNT must lie between 1 and 4");
	end

	// word-aligned register match, shared by the write and read paths
	function automatic logic reg_hit(input logic [`DSPM_ADDR_W-1:0] addr,
		input logic [`DSPM_ADDR_W-1:0] off);
		return addr[`DSPM_ADDR_W-1:2] == off[`DSPM_ADDR_W-1:2];
	endfunction : reg_hit

	// per-area strobe map: {low lane select, high lane select, write enable}
	function automatic logic [2:0] lane_map(input dspm_bus_mode_t mode, input logic cas,
		input logic we, input logic a0);
		logic [2:0] m;
		m = 3'h0;
		case (mode)
			DSPM_BUS16_2CAS: m = {cas & ~a0, cas & a0, we};
			DSPM_BUS16_1CAS: m = {cas, we & ~a0, we & a0};
			default:         m = {cas, cas, we};
		endcase
		return m;
	endfunction : lane_map

	logic [`DSPM_CTRL_W-1:0]  ctrl_q;
	logic [`DSPM_ADDR_W-1:0]  aw_addr_q;
	logic [31:0]              w_data_q;
	logic [3:0]               w_strb_q;
	logic                     aw_got_q;
	logic                     w_got_q;
	logic                     pf7_prev_q;
	logic [AN_COUNT+1:0]      pins_sync;
	logic                     pf6_sync;
	logic                     pf7_sync;
	logic [AN_COUNT-1:0]      an_sync;

	// pin levels come from outside the clock domain
	dspm_sync #(
		.WIDTH    (AN_COUNT + 2)
	) u_pin_sync (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.async_in ({analog_pin_i, pf7_pin_i, pf6_pin_i}),
		.sync_out (pins_sync)
	);

	assign pf6_sync = pins_sync[0];
	assign pf7_sync = pins_sync[1];
	assign an_sync  = pins_sync[AN_COUNT+1:2];

	// control fields
	logic                 ser2_oe;
	logic                 tmr2_en;
	logic                 tmr0_en;
	logic                 ext_trig;
	logic [AN_COUNT-1:0]  aic_sel;
	dspm_bus_mode_t       bus_mode;

	assign ser2_oe  = ctrl_q[`DSPM_SER2_OE_BIT];
	assign tmr2_en  = ctrl_q[`DSPM_TMR2_EN_BIT];
	assign tmr0_en  = ctrl_q[`DSPM_TMR0_EN_BIT];
	assign ext_trig = ctrl_q[`DSPM_EXT_TRIG_BIT];
	assign aic_sel  = ctrl_q[`DSPM_AIC_LSB +: AN_COUNT];
	assign bus_mode = dspm_bus_mode_t'(ctrl_q[`DSPM_MODE_LSB +: 2]);

	// shared pin six: serial data first, then timer two, then the port
	dspm_pin_src_t  pf6_src;
	logic           pf6_o_d;
	logic           pf6_oe_d;

	assign pf6_src  = ser2_oe ? DSPM_SRC_PERA : (tmr2_en ? DSPM_SRC_PERB : DSPM_SRC_PORT);
	assign pf6_o_d  = ser2_oe ? serial2_tx_out
		: (tmr2_en ? timer_out_two : port_f_bit_six_dat);
	assign pf6_oe_d = ser2_oe | tmr2_en | port_f_bit_six_dir;

	// shared pin seven: timer zero wins; an external trigger keeps the pin an input
	dspm_pin_src_t  pf7_src;
	logic           pf7_o_d;
	logic           pf7_oe_d;

	assign pf7_src  = tmr0_en ? DSPM_SRC_PERA : (ext_trig ? DSPM_SRC_INPUT : DSPM_SRC_PORT);
	assign pf7_o_d  = tmr0_en ? timer_out_zero : port_f_bit_seven_dat;
	assign pf7_oe_d = tmr0_en | (~ext_trig & port_f_bit_seven_dir);

	// rising edge on the synchronised trigger pin; a driven timer output
	// also reaches it, which software must intend
	logic           conv_start_d;

	assign conv_start_d = ext_trig & pf7_sync & ~pf7_prev_q;

	// digital read of a converter pin is forced low while it is analog
	logic [AN_COUNT-1:0] an_dig_d;

	assign an_dig_d = an_sync & ~aic_sel;

	// dram strobes, active high before inversion at the pin
	logic [2:0]     area4_map;
	logic [2:0]     area5_map;

	assign area4_map = lane_map(bus_mode, dram_cas_req & dram_ras4_req, dram_we_req & dram_ras4_req, dram_addr0);
	assign area5_map = lane_map(bus_mode, dram_cas_req & dram_ras5_req, dram_we_req & dram_ras5_req, dram_addr0);

	// pin and strobe registers; strobes idle high
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pf6_pin_o                <= 1'b0;
			pf6_pin_oe               <= 1'b0;
			pf7_pin_o                <= 1'b0;
			pf7_pin_oe               <= 1'b0;
			pf7_prev_q               <= 1'b0;
			port_f_bit_six_in        <= 1'b0;
			port_f_bit_seven_in      <= 1'b0;
			converter_ext_trigger    <= 1'b0;
			analog_inputs_en         <= '0;
			analog_digital_in        <= '0;
			row_strobe_area4_n       <= 1'b1;
			row_strobe_area5_n       <= 1'b1;
			area4_low_lane_select_n  <= 1'b1;
			area4_high_lane_select_n <= 1'b1;
			area4_write_enable_n     <= 1'b1;
			area5_low_lane_select_n  <= 1'b1;
			area5_high_lane_select_n <= 1'b1;
			area5_write_enable_n     <= 1'b1;
		end else begin
			pf6_pin_o                <= pf6_o_d;
			pf6_pin_oe               <= pf6_oe_d;
			pf7_pin_o                <= pf7_o_d;
			pf7_pin_oe               <= pf7_oe_d;
			pf7_prev_q               <= pf7_sync;
			port_f_bit_six_in        <= pf6_sync;
			port_f_bit_seven_in      <= pf7_sync;
			converter_ext_trigger    <= conv_start_d;
			analog_inputs_en         <= aic_sel;
			analog_digital_in        <= an_dig_d;
			row_strobe_area4_n       <= ~dram_ras4_req;
			row_strobe_area5_n       <= ~dram_ras5_req;
			area4_low_lane_select_n  <= ~area4_map[2];
			area4_high_lane_select_n <= ~area4_map[1];
			area4_write_enable_n     <= ~area4_map[0];
			area5_low_lane_select_n  <= ~area5_map[2];
			area5_high_lane_select_n <= ~area5_map[1];
			area5_write_enable_n     <= ~area5_map[0];
		end
	end

	// register bus: write commits once address and data are both held
	logic                     do_write;
	logic                     wr_ctrl;
	logic                     wr_hit;
	logic [31:0]              wmask;
	logic [`DSPM_CTRL_W-1:0]  ctrl_d;

	assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
	assign wr_hit   = reg_hit(aw_addr_q, `DSPM_CTRL_OFF) | reg_hit(aw_addr_q, `DSPM_STAT_OFF);
	assign wr_ctrl  = do_write & reg_hit(aw_addr_q, `DSPM_CTRL_OFF);
	assign wmask    = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign ctrl_d   = (ctrl_q & ~wmask[`DSPM_CTRL_W-1:0]) | (w_data_q[`DSPM_CTRL_W-1:0] & wmask[`DSPM_CTRL_W-1:0]);

	// read data: status shows who owns each pin and the live pin levels
	logic [31:0]    status_w;
	logic [31:0]    rd_data;
	logic           rd_hit;

	assign status_w = {20'h0_0000, 4'(analog_digital_in), 2'h0, pf7_sync, pf6_sync, pf7_src, pf6_src};
	assign rd_hit   = reg_hit(s_axi_araddr, `DSPM_CTRL_OFF) | reg_hit(s_axi_araddr, `DSPM_STAT_OFF);
	assign rd_data  = reg_hit(s_axi_araddr, `DSPM_CTRL_OFF) ? 32'(ctrl_q)
		: (reg_hit(s_axi_araddr, `DSPM_STAT_OFF) ? status_w : 32'h0000_0000);

	// write channels are taken independently; ready drops until the response is taken
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `DSPM_RESP_OKAY;
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			aw_addr_q     <= '0;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			ctrl_q        <= `DSPM_CTRL_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q      <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q      <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `DSPM_RESP_OKAY : `DSPM_RESP_SLVERR;
			end
			if (wr_ctrl) begin
				ctrl_q <= ctrl_d;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// one read at a time; data is captured from the address as it is taken
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `DSPM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_data;
			s_axi_rresp   <= rd_hit ? `DSPM_RESP_OKAY : `DSPM_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// checks on pin ownership and strobe mapping
	a_periph_prio_six: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		ser2_oe |=> (pf6_pin_oe && pf6_pin_o == $past(serial2_tx_out)))
		else $error("pin six not driven by serial data");

	a_serial_gate_off: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(!ser2_oe && !tmr2_en && !port_f_bit_six_dir) |=> !pf6_pin_oe)
		else $error("pin six driven with all owners off");

	a_port_six_sel: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(!ser2_oe && !tmr2_en) |=> (pf6_pin_o == $past(port_f_bit_six_dat) && pf6_pin_oe == $past(port_f_bit_six_dir)))
		else $error("pin six not following the port");

	a_port_seven_sel: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(!tmr0_en && !ext_trig) |=> (pf7_pin_oe == $past(port_f_bit_seven_dir) && pf7_pin_o == $past(port_f_bit_seven_dat)))
		else $error("pin seven not following the port");

	a_trig_start_sel: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		converter_ext_trigger |-> ($past(ext_trig) && $past(pf7_sync) && !$past(pf7_sync, 2)))
		else $error("converter start without selected trigger edge");

	a_trig_pin_input: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(ext_trig && !tmr0_en) |=> !pf7_pin_oe)
		else $error("trigger pin driven while selected as input");

	a_analog_mask_sel: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(analog_digital_in & analog_inputs_en) == '0)
		else $error("analog pin seen as digital input");

	a_lane_low_cas: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(bus_mode == DSPM_BUS16_2CAS && dram_ras4_req && dram_cas_req)
		|=> (area4_low_lane_select_n == $past(dram_addr0) && area4_high_lane_select_n == !$past(dram_addr0)))
		else $error("area four column strobe lane wrong");

	a_single_cas_we: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(bus_mode == DSPM_BUS16_1CAS && dram_ras5_req && dram_we_req && dram_cas_req)
		|=> (!area5_low_lane_select_n && area5_high_lane_select_n == $past(dram_addr0)
			&& area5_write_enable_n == !$past(dram_addr0)))
		else $error("area five write enable split wrong");

	a_row_strobe_map: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		##1 (row_strobe_area4_n == !$past(dram_ras4_req) && row_strobe_area5_n == !$past(dram_ras5_req)))
		else $error("row strobe on wrong area pin");

	a_byte_bus_cas: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(bus_mode == DSPM_BUS8 && dram_ras5_req && dram_cas_req && dram_we_req)
		|=> (!area5_low_lane_select_n && !area5_high_lane_select_n && !area5_write_enable_n))
		else $error("8-bit bus strobes not merged");

endmodule : dspm_top

`default_nettype wire
